// *** hw/hlc_map.vh ***
`ifndef HLC_MAP_VH
`define HLC_MAP_VH
// Register byte addresses.
`define HLC_ADDR_SET        8'h50
`define HLC_ADDR_CLR        8'h54
`define HLC_ADDR_STAT       8'h58
// PHY-clock-domain address windows.
`define HLC_PDOM_LO0        8'hdc
`define HLC_PDOM_HI0        8'hf0
`define HLC_PDOM_LO1        9'h100
`define HLC_PDOM_HI1        9'h11c
// Control register field positions.
`define HLC_B_CFGOK         23
`define HLC_B_UPG           22
`define HLC_B_LPS           19
`define HLC_B_PWE           18
`define HLC_B_ATT           17
`define HLC_B_SRST          16
// Reset values and the all-ones suppressed-read answer.
`define HLC_CFGOK_RST       1'b1
`define HLC_ZERO32          32'h0000_0000
`define HLC_ONES32          32'hffff_ffff
// Unused readback positions.
`define HLC_PAD_HI          8'h00
`define HLC_PAD_MID         2'b00
`define HLC_PAD_LO          16'h0000
// Software reset length in cycles.
`define HLC_SRST_CYC        4'h8
`define HLC_SRST_ONE        4'h1
`define HLC_SRST_ZERO       4'h0
`endif

// *** hw/hlc_ctrl.v ***
// Operation
// - Unused control bits read as zero
// - Power status bit gates link-PHY traffic
// - Stopped PHY clock access aborts by default
// - Suppression makes such reads return ones
// - Two offset windows lie in PHY domain
// - Posted-write bit switches posted writes
// - Attach bit cleared by either reset
// - Detached link exchanges no packets
// - Self reinit resets all link state
// - Reinit bit reads one until done
// - Set and clear addresses read same
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/100ps
`include "hlc_map.vh"
module hlc_ctrl (
    // Clock and reset.
    input  wire        mclk,
    input  wire        srst,
    // Register port.
    input  wire [8:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    output reg         reg_abort,
    // Configuration-space inputs.
    input  wire        suppress_target_abort,
    input  wire        phy_config_permitted_in,
    input  wire        phy_clk_running,
    // Link steering outputs.
    output wire        link_phy_comm_en,
    output wire        posted_write_on,
    output wire        node_attach_enable,
    output wire        phy_feature_upgrade_on,
    output wire        link_state_flush
);
    // Settable control bits and their next values.
    reg         upg_reg;
    reg         upg_next;
    reg         lps_reg;
    reg         lps_next;
    reg         pwe_reg;
    reg         pwe_next;
    reg         att_reg;
    reg         att_next;
    // Permission bit, kept apart from the settable bits.
    reg         cfgok_reg;
    // Self reinit countdown.
    reg  [3:0]  sr_cnt_reg;
    reg  [3:0]  sr_cnt_next;
    // Synchroniser flip-flops for the pin-side levels.
    reg         run_s1_reg;
    reg         run_s2_reg;
    reg         cfg_s1_reg;
    reg         cfg_s2_reg;
    // Next values of the read answer.
    reg  [31:0] rdata_next;
    reg         abort_next;
    // Decoded strobes and status.
    wire        hit_set;
    wire        hit_clr;
    wire        hit_ctrl;
    wire        wr_set;
    wire        wr_clr;
    wire        sr_busy;
    wire        sr_start;
    wire        in_win0;
    wire        in_win1;
    wire        pdom;
    wire        phy_stopped;
    wire        blocked;
    wire [31:0] ctrl_word;

    // First stage of the PHY clock status synchroniser.
    always @(posedge mclk) begin
        if (srst) begin
            run_s1_reg <= 1'b0;
        end else begin
            run_s1_reg <= phy_clk_running;
        end
    end

    // Second stage; only this flip-flop is read by the logic.
    always @(posedge mclk) begin
        if (srst) begin
            run_s2_reg <= 1'b0;
        end else begin
            run_s2_reg <= run_s1_reg;
        end
    end

    // First stage of the permission strap synchroniser.
    // It resets to the permission default so the bit does not dip after reset.
    always @(posedge mclk) begin
        if (srst) begin
            cfg_s1_reg <= `HLC_CFGOK_RST;
        end else begin
            cfg_s1_reg <= phy_config_permitted_in;
        end
    end

    // Second stage of the permission strap synchroniser.
    always @(posedge mclk) begin
        if (srst) begin
            cfg_s2_reg <= `HLC_CFGOK_RST;
        end else begin
            cfg_s2_reg <= cfg_s1_reg;
        end
    end

    // Register address decode for the set and clear addresses.
    assign hit_set  = (reg_addr == {1'b0, `HLC_ADDR_SET});
    assign hit_clr  = (reg_addr == {1'b0, `HLC_ADDR_CLR});
    assign hit_ctrl = hit_set || hit_clr;

    // Writes are ignored while a self reinit is running.
    assign wr_set   = reg_wr && hit_set && !sr_busy;
    assign wr_clr   = reg_wr && hit_clr && !sr_busy;

    // Self reinit runs while the countdown is not zero.
    assign sr_busy  = (sr_cnt_reg != `HLC_SRST_ZERO);
    assign sr_start = wr_set && reg_wdata[`HLC_B_SRST];

    // Address falls in one of the two PHY-clock windows.
    assign in_win0  = (reg_addr >= {1'b0, `HLC_PDOM_LO0}) && (reg_addr <= {1'b0, `HLC_PDOM_HI0});
    assign in_win1  = (reg_addr >= `HLC_PDOM_LO1) && (reg_addr <= `HLC_PDOM_HI1);
    assign pdom     = in_win0 || in_win1;

    // The PHY clock counts as stopped once the synchronised level is low.
    // The two-cycle lag means an access right after a stop may still complete.
    assign phy_stopped = !run_s2_reg;
    assign blocked     = pdom && phy_stopped;

    // Next value of the feature upgrade bit.
    always @* begin
        upg_next = upg_reg;
        if (wr_set) begin
            upg_next = upg_reg | reg_wdata[`HLC_B_UPG];
        end else if (wr_clr) begin
            upg_next = upg_reg & ~reg_wdata[`HLC_B_UPG];
        end
    end

    // Feature upgrade bit; cleared by either reset.
    always @(posedge mclk) begin
        if (srst || sr_busy) begin
            upg_reg <= 1'b0;
        end else begin
            upg_reg <= upg_next;
        end
    end

    // Next value of the link power status bit.
    always @* begin
        lps_next = lps_reg;
        if (wr_set) begin
            lps_next = lps_reg | reg_wdata[`HLC_B_LPS];
        end else if (wr_clr) begin
            lps_next = lps_reg & ~reg_wdata[`HLC_B_LPS];
        end
    end

    // Link power status bit; it gates all link-PHY traffic.
    always @(posedge mclk) begin
        if (srst || sr_busy) begin
            lps_reg <= 1'b0;
        end else begin
            lps_reg <= lps_next;
        end
    end

    // Next value of the posted-write bit.
    always @* begin
        pwe_next = pwe_reg;
        if (wr_set) begin
            pwe_next = pwe_reg | reg_wdata[`HLC_B_PWE];
        end else if (wr_clr) begin
            pwe_next = pwe_reg & ~reg_wdata[`HLC_B_PWE];
        end
    end

    // Posted-write bit; software is trusted to change it only while detached.
    always @(posedge mclk) begin
        if (srst || sr_busy) begin
            pwe_reg <= 1'b0;
        end else begin
            pwe_reg <= pwe_next;
        end
    end

    // Next value of the node attach bit.
    always @* begin
        att_next = att_reg;
        if (wr_set) begin
            att_next = att_reg | reg_wdata[`HLC_B_ATT];
        end else if (wr_clr) begin
            att_next = att_reg & ~reg_wdata[`HLC_B_ATT];
        end
    end

    // Node attach bit; either reset detaches the node at once.
    always @(posedge mclk) begin
        if (srst || sr_busy) begin
            att_reg <= 1'b0;
        end else begin
            att_reg <= att_next;
        end
    end

    // Permission bit follows the synchronised strap.
    // A self reinit leaves it alone, as it is configuration-space state.
    always @(posedge mclk) begin
        if (srst) begin
            cfgok_reg <= `HLC_CFGOK_RST;
        end else begin
            cfgok_reg <= cfg_s2_reg;
        end
    end

    // Countdown next value: load on a request, count down while busy.
    always @* begin
        sr_cnt_next = sr_cnt_reg;
        if (sr_busy) begin
            sr_cnt_next = sr_cnt_reg - `HLC_SRST_ONE;
        end else if (sr_start) begin
            sr_cnt_next = `HLC_SRST_CYC;
        end
    end

    // Countdown register; only a hard reset ends it early.
    always @(posedge mclk) begin
        if (srst) begin
            sr_cnt_reg <= `HLC_SRST_ZERO;
        end else begin
            sr_cnt_reg <= sr_cnt_next;
        end
    end

    // Readback image; unused positions stay zero.
    assign ctrl_word = {`HLC_PAD_HI,
                        cfgok_reg,
                        upg_reg,
                        `HLC_PAD_MID,
                        lps_reg,
                        pwe_reg,
                        att_reg,
                        sr_busy,
                        `HLC_PAD_LO};

    // Answer for the next cycle: data, all ones or an abort.
    // Every path starts from zero so nothing lingers past its cycle.
    always @* begin
        rdata_next = `HLC_ZERO32;
        abort_next = 1'b0;
        if (reg_rd) begin
            if (blocked) begin
                if (suppress_target_abort) begin
                    rdata_next = `HLC_ONES32;
                end else begin
                    abort_next = 1'b1;
                end
            end else if (hit_ctrl) begin
                rdata_next = ctrl_word;
            end else begin
                rdata_next = `HLC_ZERO32;
            end
        end else if (reg_wr) begin
            abort_next = blocked && !suppress_target_abort;
        end
    end

    // Read data and abort stand only in the cycle after the strobe.
    always @(posedge mclk) begin
        if (srst) begin
            reg_rdata <= `HLC_ZERO32;
            reg_abort <= 1'b0;
        end else begin
            reg_rdata <= rdata_next;
            reg_abort <= abort_next;
        end
    end

    // Steering outputs towards the rest of the link.
    assign link_phy_comm_en       = lps_reg;
    assign posted_write_on        = pwe_reg;
    assign node_attach_enable     = att_reg;
    assign phy_feature_upgrade_on = upg_reg;
    // The flush level lasts exactly as long as the reinit bit reads one.
    assign link_state_flush       = sr_busy;
endmodule // hlc_ctrl

// *** verif/hlc_ctrl_asserts.sv ***
`timescale 1ns/100ps
module hlc_chk (
    // All ports of the control block, observed only.
    input logic        mclk, srst, reg_wr, reg_rd, reg_abort, suppress_target_abort, phy_config_permitted_in,
    input logic        phy_clk_running, link_phy_comm_en, posted_write_on, node_attach_enable,
    input logic        phy_feature_upgrade_on, link_state_flush,
    input logic [8:0]  reg_addr,
    input logic [31:0] reg_wdata, reg_rdata
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // Window decode and an accepted set-address write.
    wire win = (reg_addr >= 9'h0dc && reg_addr <= 9'h0f0) || (reg_addr >= 9'h100 && reg_addr <= 9'h11c);
    wire w50 = reg_wr && reg_addr == 9'h050 && !link_state_flush;
    rsvd_zero_a: assert property (reg_rd && reg_addr == 9'h050 |=> reg_rdata[31:24] == 8'h00 &&
        reg_rdata[21:20] == 2'h0 && reg_rdata[15:0] == 16'h0000) else $error("reserved bits set");
    bits_echo_a: assert property (reg_rd && reg_addr == 9'h054 |=> reg_rdata[22:17] ==
        {phy_feature_upgrade_on, 2'h0, link_phy_comm_en, posted_write_on, node_attach_enable}) else $error("bits differ");
    stop_abort_a: assert property (!phy_clk_running [*4] ##0 (reg_rd || reg_wr) && win && !suppress_target_abort
        |=> reg_abort) else $error("no abort");
    stop_ones_a: assert property (!phy_clk_running [*4] ##0 reg_rd && win && suppress_target_abort
        |=> reg_rdata == 32'hffff_ffff && !reg_abort) else $error("no ones");
    flush_len_a: assert property ($rose(link_state_flush) |-> link_state_flush [*8] ##1 !link_state_flush)
        else $error("flush length");
    flush_clear_a: assert property (link_state_flush |=> !node_attach_enable && !posted_write_on &&
        !link_phy_comm_en && !phy_feature_upgrade_on) else $error("flush kept bits");
    flush_start_a: assert property (w50 && reg_wdata[16] |=> link_state_flush) else $error("no flush");
    set_bit_a: assert property (w50 && reg_wdata[17] && !reg_wdata[16] |=> node_attach_enable) else $error("no set");
    clear_bit_a: assert property (reg_wr && reg_addr == 9'h054 && reg_wdata[18] |=> !posted_write_on)
        else $error("no clear");
endmodule // hlc_chk
bind hlc_ctrl hlc_chk hlc_chk_inst (.*);

// *** verif/hlc_ctrl_test.sv ***
`timescale 1ns/100ps
module hlc_ctrl_test;
    logic        mclk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, suppress_target_abort = 1'b0;
    logic        phy_config_permitted_in = 1'b1, phy_clk_running = 1'b1, reg_abort, link_phy_comm_en;
    logic        posted_write_on, node_attach_enable, phy_feature_upgrade_on, link_state_flush;
    logic [8:0]  reg_addr = 9'h000;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rnd = 32'hb49d, m = 32'h0, d = 32'h0;
    // Power-up settling wait, shortened for the bench.
    localparam int SETTLE = 32;
    logic [8:0]  win [4] = '{9'h0dc, 9'h0f0, 9'h100, 9'h11c};
    integer      fail_count = 0, n_tests = 0, i;
    hlc_ctrl hlc_ctrl_inst (.*);
    // Free-running 50 MHz clock.
    always #10 mclk = ~mclk;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    // One strobe cycle; read data and abort are settled on return.
    task acc(input logic w, input logic [8:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
    endtask
    task test_done;
        if (fail_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Watchdog against a hung run, more than eight times the longest possible run.
    initial begin
        #100000;
        fail_count++;
        test_done;
    end
    // Main sequence: model m holds the settable bits.
    initial begin
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        repeat (4) @(posedge mclk);
        acc(0, 9'h050, 0);
        chk(reg_rdata, 32'h0080_0000);
        for (i = 0; i < 24; i++) begin
            rnd = xs(rnd);
            d = rnd & ~32'h1_0000;
            if (m[17]) d &= ~32'h4_0000;
            if (!m[17] || !phy_config_permitted_in) d &= ~32'h40_0000;
            acc(1, rnd[0] ? 9'h054 : 9'h050, d);
            if (!rnd[0] && d[19] && !m[19]) repeat (SETTLE) @(posedge mclk);
            m = rnd[0] ? m & ~d : m | d & 32'h4e_0000;
            acc(0, rnd[1] ? 9'h054 : 9'h050, 0);
            chk(reg_rdata, m | 32'h0080_0000);
            chk({phy_feature_upgrade_on, link_phy_comm_en, posted_write_on, node_attach_enable}, {m[22], m[19:17]});
        end
        acc(1, 9'h054, 32'h0002_0000);
        acc(1, 9'h050, 32'h0004_0000);
        acc(1, 9'h050, 32'h0002_0000);
        acc(1, 9'h050, 32'h0040_0000);
        acc(1, 9'h050, 32'h0001_0000);
        acc(1, 9'h050, 32'h0002_0000);
        acc(0, 9'h050, 0);
        chk(reg_rdata & 32'h1_0000, 32'h1_0000);
        repeat (8) @(posedge mclk);
        acc(0, 9'h054, 0);
        chk(reg_rdata, 32'h0080_0000);
        @(posedge mclk) phy_config_permitted_in <= 1'b0;
        repeat (4) @(posedge mclk);
        acc(0, 9'h054, 0);
        chk(reg_rdata, 32'h0);
        @(posedge mclk) phy_config_permitted_in <= 1'b1;
        repeat (4) @(posedge mclk);
        acc(0, 9'h050, 0);
        chk(reg_rdata, 32'h0080_0000);
        @(posedge mclk) phy_clk_running <= 1'b0;
        repeat (4) @(posedge mclk);
        for (i = 0; i < 4; i++) begin
            @(posedge mclk) suppress_target_abort <= i[0];
            acc(0, win[i], 0);
            chk(reg_rdata, i[0] ? 32'hffff_ffff : 32'h0);
            chk(reg_abort, !i[0]);
        end
        acc(0, 9'h058, 0);
        chk(reg_rdata, 32'h0);
        @(posedge mclk) phy_clk_running <= 1'b1;
        repeat (4) @(posedge mclk);
        acc(1, 9'h050, 32'h0002_0000);
        @(posedge mclk) srst <= 1'b1;
        @(posedge mclk) srst <= 1'b0;
        repeat (4) @(posedge mclk);
        chk(node_attach_enable, 0);
        test_done;
    end
endmodule // hlc_ctrl_test
